// >>> src/telemetry_peak_registers.v
// Telemetry read-back words and peak-hold registers behind the command port
`timescale 1ns/1ps
`include "telemetry_regs.vh"

//////////////////////////////////////////////////////////////////////////////
module telemetry_peak_registers #(
    parameter DUTY_W = `DUTY_WIDTH_DEFAULT
) (
    input  wire                mclk,
    input  wire                rst,
    // Re-initialisation events from the control logic
    input  wire                run_cycle,
    input  wire                maker_soft_reset,
    // Conversion front end
    input  wire                conv_done,
    input  wire [15:0]         vout_sample,
    input  wire [15:0]         vin_sample,
    input  wire [15:0]         sense_sample,
    input  wire [DUTY_W-1:0]   duty_fraction,
    input  wire [15:0]         die_temp_sample,
    input  wire [15:0]         ext_temp_sample,
    // Power stage state
    input  wire                operation_on,
    input  wire                drivers_on,
    input  wire                discontinuous,
    input  wire [7:0]          maker_configuration_register,
    // Decoded command port from the serial interface
    input  wire                rd_req,
    input  wire                wr_req,
    input  wire [7:0]          cmd_code,
    input  wire [1:0]          wr_byte_count,
    output wire                rd_valid,
    output wire [15:0]         rd_data,
    output wire [1:0]          rd_byte_count,
    output wire                rd_error,
    output wire                wr_ack,
    output wire                wr_error
);

    //////////////////////////////////////////////////////////////////////////
    // Power state and re-initialisation

    wire        standby;
    wire        reinit;
    wire        temp_source_ext;
    wire        conv_take;
    wire        iin_update;
    wire        iout_force;

    assign standby = ~operation_on & ~drivers_on;
    assign reinit  = run_cycle | maker_soft_reset;
    assign temp_source_ext =
        maker_configuration_register[`TEMP_SOURCE_BIT];

    // Re-init wins over a conversion landing in the same cycle
    assign conv_take  = conv_done & ~reinit;
    // Input current only tracks while the power stage is live
    assign iin_update = conv_take & ~standby;
    assign iout_force = ~reinit & (standby | discontinuous);

    //////////////////////////////////////////////////////////////////////////
    // Output current: sense voltage scaled by the duty fraction

    wire signed [DUTY_W:0]     duty_signed;
    wire signed [DUTY_W+16:0]  iout_product;
    wire [15:0]                iout_scaled;

    // Zero-extended so a duty near full scale never reads negative
    assign duty_signed  = {1'b0, duty_fraction};
    assign iout_product = $signed(sense_sample) * duty_signed;
    // Fraction full scale is two to DUTY_W, so drop that many bits
    assign iout_scaled  = iout_product[DUTY_W+15:DUTY_W];

    //////////////////////////////////////////////////////////////////////////
    // Reading registers

    reg  [15:0] vout_reading_reg;
    reg  [15:0] vin_reading_reg;
    reg  [15:0] iin_reading_reg;
    reg  [15:0] iout_reading_reg;
    reg  [15:0] temp_reading_reg;
    reg  [15:0] vout_reading_next;
    reg  [15:0] vin_reading_next;
    reg  [15:0] iin_reading_next;
    reg  [15:0] iout_reading_next;
    reg  [15:0] temp_reading_next;

    always @* begin
        vout_reading_next = vout_reading_reg;
        vin_reading_next  = vin_reading_reg;
        iin_reading_next  = iin_reading_reg;
        iout_reading_next = iout_reading_reg;
        temp_reading_next = temp_reading_reg;
        if (reinit) begin
            vout_reading_next = `TELEMETRY_INIT_VALUE;
            vin_reading_next  = `TELEMETRY_INIT_VALUE;
            iin_reading_next  = `TELEMETRY_INIT_VALUE;
            iout_reading_next = `TELEMETRY_INIT_VALUE;
            temp_reading_next = `TELEMETRY_INIT_VALUE;
        end else if (conv_done) begin
            vout_reading_next = vout_sample;
            vin_reading_next  = vin_sample;
            // Frozen in standby so the last live figure stays readable
            if (iin_update)
                iin_reading_next = sense_sample;
            iout_reading_next = iout_scaled;
            if (temp_source_ext)
                temp_reading_next = ext_temp_sample;
            else
                temp_reading_next = die_temp_sample;
        end
        // Forcing applies in every cycle without a re-init, not only at conversion
        if (iout_force)
            iout_reading_next = `OUTPUT_CURRENT_FORCED;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            vout_reading_reg <= `TELEMETRY_INIT_VALUE;
            vin_reading_reg  <= `TELEMETRY_INIT_VALUE;
            iin_reading_reg  <= `TELEMETRY_INIT_VALUE;
            iout_reading_reg <= `TELEMETRY_INIT_VALUE;
            temp_reading_reg <= `TELEMETRY_INIT_VALUE;
        end else begin
            vout_reading_reg <= vout_reading_next;
            vin_reading_reg  <= vin_reading_next;
            iin_reading_reg  <= iin_reading_next;
            iout_reading_reg <= iout_reading_next;
            temp_reading_reg <= temp_reading_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Command decode for writes

    reg         cmd_is_peak;
    reg         cmd_is_reading;
    reg  [4:0]  peak_sel;
    wire        wr_len_ok;
    wire        wr_peak_ok;
    wire        wr_clear_all_ok;
    wire [4:0]  peak_clear;
    wire [4:0]  peak_clear_one;
    wire        clear_every;
    // Delayed by one cycle so monitors see the reading just taken
    reg         conv_seen_reg;

    always @* begin
        cmd_is_peak    = 1'b1;
        cmd_is_reading = 1'b0;
        peak_sel       = 5'h00;
        case (cmd_code)
            `CMD_OUTPUT_VOLTAGE_MAX_HOLD: peak_sel = 5'h01;
            `CMD_INPUT_VOLTAGE_MAX_HOLD:  peak_sel = 5'h02;
            `CMD_INPUT_CURRENT_MAX_HOLD:  peak_sel = 5'h04;
            `CMD_OUTPUT_CURRENT_MAX_HOLD: peak_sel = 5'h08;
            `CMD_TEMPERATURE_MAX_HOLD:    peak_sel = 5'h10;
            `CMD_OUTPUT_VOLTAGE_READING,
            `CMD_INPUT_VOLTAGE_READING,
            `CMD_INPUT_CURRENT_READING,
            `CMD_OUTPUT_CURRENT_READING,
            `CMD_TEMPERATURE_READING: begin
                cmd_is_peak    = 1'b0;
                cmd_is_reading = 1'b1;
            end
            default: cmd_is_peak = 1'b0;
        endcase
    end

    assign wr_len_ok       = (wr_byte_count <= `WRITE_BYTES_MAX);
    assign wr_peak_ok      = wr_req & cmd_is_peak & wr_len_ok;
    assign wr_clear_all_ok = wr_req & wr_len_ok &
                             (cmd_code == `CMD_CLEAR_ALL_MAX_HOLDS);
    // Payload bytes are never looked at: only the command and the byte count matter
    assign peak_clear_one = {5{wr_peak_ok}} & peak_sel;
    assign clear_every    = wr_clear_all_ok | reinit;
    assign peak_clear     = peak_clear_one | {5{clear_every}};

    always @(posedge mclk or posedge rst) begin
        if (rst)
            conv_seen_reg <= 1'b0;
        else
            conv_seen_reg <= conv_take;
    end

    //////////////////////////////////////////////////////////////////////////
    // Peak monitors, one per tracked reading

    wire [15:0] vout_max_hold;
    wire [15:0] vin_max_hold;
    wire [15:0] iin_max_hold;
    wire [15:0] iout_max_hold;
    wire [15:0] temp_max_hold;

    peak_monitor #(.WIDTH(16)) vout_peak_mon (
        .mclk         (mclk),
        .rst          (rst),
        .clear        (peak_clear[0]),
        .sample_valid (conv_seen_reg),
        .sample       (vout_reading_reg),
        .peak         (vout_max_hold)
    );

    peak_monitor #(.WIDTH(16)) vin_peak_mon (
        .mclk         (mclk),
        .rst          (rst),
        .clear        (peak_clear[1]),
        .sample_valid (conv_seen_reg),
        .sample       (vin_reading_reg),
        .peak         (vin_max_hold)
    );

    peak_monitor #(.WIDTH(16)) iin_peak_mon (
        .mclk         (mclk),
        .rst          (rst),
        .clear        (peak_clear[2]),
        .sample_valid (conv_seen_reg),
        .sample       (iin_reading_reg),
        .peak         (iin_max_hold)
    );

    peak_monitor #(.WIDTH(16)) iout_peak_mon (
        .mclk         (mclk),
        .rst          (rst),
        .clear        (peak_clear[3]),
        .sample_valid (conv_seen_reg),
        .sample       (iout_reading_reg),
        .peak         (iout_max_hold)
    );

    // Mixing sources in one watch is left to software to avoid
    peak_monitor #(.WIDTH(16)) temp_peak_mon (
        .mclk         (mclk),
        .rst          (rst),
        .clear        (peak_clear[4]),
        .sample_valid (conv_seen_reg),
        .sample       (temp_reading_reg),
        .peak         (temp_max_hold)
    );

    //////////////////////////////////////////////////////////////////////////
    // Read mux and answer registers

    reg  [15:0] rd_mux;
    reg         rd_known;
    reg         rd_valid_reg;
    reg  [15:0] rd_data_reg;
    reg  [1:0]  rd_byte_count_reg;
    reg         rd_error_reg;
    reg         wr_ack_reg;
    reg         wr_error_reg;
    wire        wr_good;
    wire        wr_bad;
    wire        rd_good;
    wire        rd_bad;

    always @* begin
        rd_mux   = 16'h0000;
        rd_known = 1'b1;
        case (cmd_code)
            `CMD_OUTPUT_VOLTAGE_READING:  rd_mux = vout_reading_reg;
            `CMD_INPUT_VOLTAGE_READING:   rd_mux = vin_reading_reg;
            `CMD_INPUT_CURRENT_READING:   rd_mux = iin_reading_reg;
            `CMD_OUTPUT_CURRENT_READING:  rd_mux = iout_reading_reg;
            `CMD_TEMPERATURE_READING:     rd_mux = temp_reading_reg;
            `CMD_OUTPUT_VOLTAGE_MAX_HOLD: rd_mux = vout_max_hold;
            `CMD_INPUT_VOLTAGE_MAX_HOLD:  rd_mux = vin_max_hold;
            `CMD_INPUT_CURRENT_MAX_HOLD:  rd_mux = iin_max_hold;
            `CMD_OUTPUT_CURRENT_MAX_HOLD: rd_mux = iout_max_hold;
            `CMD_TEMPERATURE_MAX_HOLD:    rd_mux = temp_max_hold;
            default:                      rd_known = 1'b0;
        endcase
    end

    // Unknown codes, clear-all among them, answer zero with no bytes
    assign rd_good = rd_req & rd_known;
    assign rd_bad  = rd_req & ~rd_known;
    // Readings refuse writes; clear-all is write-only
    assign wr_good = wr_peak_ok | wr_clear_all_ok;
    assign wr_bad  = wr_req & ~wr_good;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
            rd_error_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_good;
            rd_error_reg <= rd_bad;
        end
    end

    // Data and count stand until the next read request
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data_reg       <= 16'h0000;
            rd_byte_count_reg <= 2'd0;
        end else if (rd_good) begin
            rd_data_reg       <= rd_mux;
            rd_byte_count_reg <= `READ_BYTE_COUNT;
        end else if (rd_bad) begin
            rd_data_reg       <= 16'h0000;
            rd_byte_count_reg <= 2'd0;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ack_reg   <= 1'b0;
            wr_error_reg <= 1'b0;
        end else begin
            wr_ack_reg   <= wr_good;
            wr_error_reg <= wr_bad;
        end
    end

    assign rd_valid      = rd_valid_reg;
    assign rd_data       = rd_data_reg;
    assign rd_byte_count = rd_byte_count_reg;
    assign rd_error      = rd_error_reg;
    assign wr_ack        = wr_ack_reg;
    assign wr_error      = wr_error_reg;

endmodule // telemetry_peak_registers

// >>> src/telemetry_regs.vh
// Command codes, field positions and reset values for the telemetry bank
`ifndef TELEMETRY_REGS_VH
`define TELEMETRY_REGS_VH

// Command codes seen on the decoded serial command port
`define CMD_OUTPUT_VOLTAGE_READING   8'h10
`define CMD_INPUT_VOLTAGE_READING    8'h11
`define CMD_INPUT_CURRENT_READING    8'h12
`define CMD_OUTPUT_CURRENT_READING   8'h13
`define CMD_TEMPERATURE_READING      8'h14
`define CMD_OUTPUT_VOLTAGE_MAX_HOLD  8'h20
`define CMD_INPUT_VOLTAGE_MAX_HOLD   8'h21
`define CMD_TEMPERATURE_MAX_HOLD     8'h22
`define CMD_OUTPUT_CURRENT_MAX_HOLD  8'h23
`define CMD_INPUT_CURRENT_MAX_HOLD   8'h24
`define CMD_CLEAR_ALL_MAX_HOLDS      8'h25

// Value of every telemetry word before its first conversion
`define TELEMETRY_INIT_VALUE         16'h8000
// Forced output-current word in standby or discontinuous conduction
`define OUTPUT_CURRENT_FORCED        16'h8000

// Temperature source select position in the maker configuration byte
`define TEMP_SOURCE_BIT              2

// Data bytes returned per reading, and most write bytes accepted
`define READ_BYTE_COUNT              2'd2
`define WRITE_BYTES_MAX              2'd2

// Default width of the duty-cycle fraction from the modulator
`define DUTY_WIDTH_DEFAULT           10

`endif

// >>> src/peak_monitor.v
// Signed peak-hold monitor for one telemetry reading
`timescale 1ns/1ps
`include "telemetry_regs.vh"

module peak_monitor #(
    parameter WIDTH = 16
) (
    input  wire                    mclk,
    input  wire                    rst,
    input  wire                    clear,
    input  wire                    sample_valid,
    input  wire [WIDTH-1:0]        sample,
    output wire [WIDTH-1:0]        peak
);

    reg  [WIDTH-1:0] peak_reg;
    reg  [WIDTH-1:0] peak_next;

    always @* begin
        peak_next = peak_reg;
        if (clear) begin
            // A sample landing with the clear starts the new watch
            if (sample_valid)
                peak_next = sample;
            else
                peak_next = `TELEMETRY_INIT_VALUE;
        end else if (sample_valid &&
                     ($signed(sample) > $signed(peak_reg))) begin
            peak_next = sample;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            peak_reg <= `TELEMETRY_INIT_VALUE;
        else
            peak_reg <= peak_next;
    end

    assign peak = peak_reg;

endmodule // peak_monitor

// >>> test/telemetry_peak_registers_chk.sv
// Command-port assertions for the telemetry and peak-hold bank
`timescale 1ns/1ps
module telemetry_peak_registers_chk (
    input wire        mclk,
    input wire        rst,
    input wire        run_cycle,
    input wire        maker_soft_reset,
    input wire        conv_done,
    input wire        operation_on,
    input wire        drivers_on,
    input wire        discontinuous,
    input wire        rd_req,
    input wire        wr_req,
    input wire [7:0]  cmd_code,
    input wire [1:0]  wr_byte_count,
    input wire        rd_valid,
    input wire [15:0] rd_data,
    input wire [1:0]  rd_byte_count,
    input wire        rd_error,
    input wire        wr_ack,
    input wire        wr_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire forced = (!operation_on && !drivers_on) || discontinuous;
    wire pk_cmd = cmd_code >= 8'h20 && cmd_code <= 8'h24;
    wire bad_wr = cmd_code < 8'h20 || cmd_code > 8'h25 ||
                  wr_byte_count == 2'd3;
    wire rdg_cmd = cmd_code >= 8'h10 && cmd_code <= 8'h14;
    sequence s_clear;
        !conv_done ##1 (wr_req && pk_cmd && !bad_wr);
    endsequence
    sequence s_reinit;
        run_cycle || maker_soft_reset;
    endsequence
    property p_rd_answer;
        rd_req |=> rd_valid != rd_error;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read without exactly one answer");
    property p_rd_count;
        rd_valid |-> rd_byte_count == 2'd2 && !rd_error;
    endproperty
    a_rd_count: assert property (p_rd_count)
        else $error("good read without two bytes");
    property p_wr_refused;
        wr_req && bad_wr |=> wr_error && !wr_ack;
    endproperty
    a_wr_refused: assert property (p_wr_refused)
        else $error("illegal write not refused");
    property p_wr_accept;
        wr_req && !bad_wr |=> wr_ack && !wr_error;
    endproperty
    a_wr_accept: assert property (p_wr_accept)
        else $error("peak write not accepted");
    property p_clear_peak;
        s_clear ##1 (rd_req && cmd_code == $past(cmd_code))
            |=> rd_valid && rd_data == 16'h8000;
    endproperty
    a_clear_peak: assert property (p_clear_peak)
        else $error("peak not cleared by write");
    property p_iout_forced;
        $past(forced) && rd_req && cmd_code == 8'h13 |=> rd_data == 16'h8000;
    endproperty
    a_iout_forced: assert property (p_iout_forced)
        else $error("output current not forced");
    property p_reinit;
        s_reinit ##1 (rd_req && rdg_cmd) |=> rd_data == 16'h8000;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("reading not initialised");
    property p_clear_all_rd;
        rd_req && cmd_code == 8'h25 |=> rd_error && rd_byte_count == 2'd0;
    endproperty
    a_clear_all_rd: assert property (p_clear_all_rd)
        else $error("write-only command readable");
    property p_rd_hold;
        !rd_req |=> $stable(rd_data) && $stable(rd_byte_count);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without request");
    property p_wr_quiet;
        !wr_req |=> !wr_ack && !wr_error;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet)
        else $error("write answer without request");
endmodule // telemetry_peak_registers_chk

bind telemetry_peak_registers telemetry_peak_registers_chk chk_u (.*);

// >>> test/telemetry_host.sv
// Host model issuing reads and writes on the decoded command port
`timescale 1ns/1ps
module telemetry_host (
    input  wire        mclk,
    input  wire        rd_valid,
    input  wire [15:0] rd_data,
    input  wire [1:0]  rd_byte_count,
    input  wire        rd_error,
    input  wire        wr_ack,
    input  wire        wr_error,
    output logic       rd_req,
    output logic       wr_req,
    output logic [7:0] cmd_code,
    output logic [1:0] wr_byte_count
);
    logic [15:0] data;
    logic [1:0]  cnt;
    logic        good;
    logic        bad;
    initial begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        cmd_code = 8'h00;
        wr_byte_count = 2'd0;
    end
    // Strobe left up so calls can run back to back; idle() drops it
    task automatic op(input logic r, input logic [7:0] c, input logic [1:0] n);
        rd_req = r;
        wr_req = !r;
        cmd_code = c;
        wr_byte_count = n;
        @(posedge mclk);
        #1;
        data = rd_data;
        cnt = rd_byte_count;
        good = r ? rd_valid : wr_ack;
        bad = r ? rd_error : wr_error;
    endtask
    // Released lines toggle; a second idle() in a row restores the last valid code
    task automatic idle();
        rd_req = 1'b0;
        wr_req = 1'b0;
        cmd_code = ~cmd_code;
        wr_byte_count = ~wr_byte_count;
        @(posedge mclk);
        #1;
    endtask
endmodule // telemetry_host

// >>> test/telemetry_peak_registers_bench.sv
// Self-checking bench for the telemetry and peak-hold bank
`timescale 1ns/1ps
module telemetry_peak_registers_bench;
    logic        mclk, rst, run_cycle, maker_soft_reset, conv_done;
    logic [15:0] vout_sample, vin_sample, sense_sample, rd_data;
    logic [15:0] die_temp_sample, ext_temp_sample;
    logic [9:0]  duty_fraction;
    logic        operation_on, drivers_on, discontinuous;
    logic [7:0]  maker_configuration_register, cmd_code;
    logic        rd_req, wr_req, rd_valid, rd_error, wr_ack, wr_error;
    logic [1:0]  wr_byte_count, rd_byte_count;
    int          err_count, comparisons, i, k;
    logic [15:0] rdg [5];
    logic [15:0] pk [5];
    logic [7:0]  pcode [5] = '{8'h20, 8'h21, 8'h24, 8'h23, 8'h22};

    telemetry_peak_registers #(.DUTY_W(10)) dut_u (
        .mclk(mclk), .rst(rst), .run_cycle(run_cycle),
        .maker_soft_reset(maker_soft_reset), .conv_done(conv_done),
        .vout_sample(vout_sample), .vin_sample(vin_sample),
        .sense_sample(sense_sample), .duty_fraction(duty_fraction),
        .die_temp_sample(die_temp_sample), .ext_temp_sample(ext_temp_sample),
        .operation_on(operation_on), .drivers_on(drivers_on),
        .discontinuous(discontinuous),
        .maker_configuration_register(maker_configuration_register),
        .rd_req(rd_req), .wr_req(wr_req), .cmd_code(cmd_code),
        .wr_byte_count(wr_byte_count), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_byte_count(rd_byte_count),
        .rd_error(rd_error), .wr_ack(wr_ack), .wr_error(wr_error));
    telemetry_host host_u (
        .mclk(mclk), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_byte_count(rd_byte_count), .rd_error(rd_error),
        .wr_ack(wr_ack), .wr_error(wr_error), .rd_req(rd_req),
        .wr_req(wr_req), .cmd_code(cmd_code), .wr_byte_count(wr_byte_count));

    //////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask
    // Answer flags and byte count packed as {good, bad, count}
    function automatic logic [15:0] stat();
        return {12'h000, host_u.good, host_u.bad, host_u.cnt};
    endfunction
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        host_u.op(1'b1, c, 2'd0);
        check(host_u.data, exp);
        check(stat(), 16'h000a);
    endtask
    task automatic wr(input logic [7:0] c, input logic [1:0] n,
                      input logic ok);
        host_u.op(1'b0, c, n);
        check(stat() >> 2, {14'h0000, ok, !ok});
    endtask
    task automatic readall();
        for (int j = 0; j < 5; j++) begin
            rd(8'(8'h10 + j), rdg[j]);
            rd(pcode[j], pk[j]);
        end
        host_u.idle();
    endtask
    task automatic conv();
        logic signed [31:0] p;
        {operation_on, drivers_on, discontinuous} = 3'($urandom);
        maker_configuration_register = 8'($urandom);
        {vout_sample, vin_sample} = $urandom;
        {sense_sample, die_temp_sample} = $urandom;
        ext_temp_sample = 16'($urandom);
        duty_fraction = 10'($urandom);
        p = $signed(sense_sample) * $signed({1'b0, duty_fraction});
        conv_done = 1'b1;
        rdg[0] = vout_sample;
        rdg[1] = vin_sample;
        if (operation_on || drivers_on)
            rdg[2] = sense_sample;
        rdg[3] = p[25:10];
        if ((!operation_on && !drivers_on) || discontinuous)
            rdg[3] = 16'h8000;
        rdg[4] = maker_configuration_register[2] ? ext_temp_sample
                                                 : die_temp_sample;
        for (int j = 0; j < 5; j++)
            if ($signed(rdg[j]) > $signed(pk[j]))
                pk[j] = rdg[j];
        @(posedge mclk);
        #1;
        conv_done = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic init_model();
        for (int j = 0; j < 5; j++) begin
            rdg[j] = 16'h8000;
            pk[j] = 16'h8000;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #(50 * 5000);
        err_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hc938));
        {rst, run_cycle, maker_soft_reset, conv_done} = 4'b1000;
        {vout_sample, vin_sample, sense_sample} = 48'h0;
        {die_temp_sample, ext_temp_sample, duty_fraction} = 42'h0;
        {operation_on, drivers_on, discontinuous} = 3'b110;
        maker_configuration_register = 8'h00;
        init_model();
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        readall();
        $display("reset values test done");
        repeat (12) begin
            conv();
            readall();
        end
        $display("conversion test done");
        for (i = 0; i < 5; i++)
            wr(8'(8'h10 + i), 2'(i), 1'b0);
        wr(8'h20, 2'd3, 1'b0);
        wr(8'h30, 2'd0, 1'b0);
        host_u.op(1'b1, 8'h25, 2'd0);
        check(host_u.data, 16'h0000);
        check(stat(), 16'h0004);
        readall();
        $display("refusal test done");
        for (i = 0; i < 5; i++) begin
            conv();
            if (i == 4)
                maker_configuration_register[2] ^= 1'b1;
            wr(pcode[i], 2'(i % 3), 1'b1);
            pk[i] = 16'h8000;
            rd(pcode[i], 16'h8000);
            host_u.idle();
            readall();
        end
        $display("single clear test done");
        conv();
        wr(8'h25, 2'd1, 1'b1);
        for (i = 0; i < 5; i++)
            pk[i] = 16'h8000;
        readall();
        $display("clear all test done");
        for (k = 0; k < 2; k++) begin
            conv();
            {run_cycle, maker_soft_reset} = k ? 2'b01 : 2'b10;
            host_u.idle();
            {run_cycle, maker_soft_reset} = 2'b00;
            init_model();
            readall();
        end
        $display("reinit test done");
        stop_test();
    end
endmodule // telemetry_peak_registers_bench
